// ### rtl/lcgis_pkg.sv
// Constants, field layouts and types for the gate input selection block.
// Assumes a 32-bit Avalon-MM register bus with word-aligned byte addresses.
package lcgis_pkg;

  // Register byte offsets, one aligned word each
  localparam logic [4:0] LCGIS_OFS_DATA3_SEL = 5'h00;
  localparam logic [4:0] LCGIS_OFS_DATA4_SEL = 5'h04;
  localparam logic [4:0] LCGIS_OFS_GATE0_EN = 5'h08;
  localparam logic [4:0] LCGIS_OFS_GATE1_EN = 5'h0C;
  localparam logic [4:0] LCGIS_OFS_STATUS = 5'h10;

  // Bus geometry
  localparam int LCGIS_ADDR_WIDTH = 5;
  localparam int LCGIS_DATA_WIDTH = 32;
  localparam int LCGIS_BE_WIDTH = 4;

  // Source select field: bits 4..0, bits 7..5 unimplemented
  localparam int LCGIS_SEL_LSB = 0;
  localparam int LCGIS_SEL_WIDTH = 5;
  localparam int LCGIS_NUM_SOURCES = 32;

  // Gate enable layout: channel k (0 = first) owns bits 2k+1 (true) and 2k (inverted)
  localparam int LCGIS_NUM_CHANNELS = 4;
  localparam int LCGIS_EN_WIDTH = 8;
  localparam int LCGIS_EN_TRUE_OFS = 1;
  localparam int LCGIS_EN_INV_OFS = 0;
  localparam int LCGIS_NUM_GATES = 2;

  // Status layout: channel levels in 3..0, gate outputs in 5..4
  localparam int LCGIS_STAT_CHAN_LSB = 0;
  localparam int LCGIS_STAT_GATE_LSB = 4;

  // Reset values
  localparam logic [4:0] LCGIS_SEL_RESET = 5'h00;
  localparam logic [7:0] LCGIS_EN_RESET = 8'h00;
  localparam logic [31:0] LCGIS_RDATA_ZERO = 32'h0000_0000;

  // Decoded register selection
  typedef enum logic [2:0] {
    LCGIS_REG_DATA3_SEL,
    LCGIS_REG_DATA4_SEL,
    LCGIS_REG_GATE0_EN,
    LCGIS_REG_GATE1_EN,
    LCGIS_REG_STATUS,
    LCGIS_REG_NONE
  } lcgis_reg_type;

endpackage

// ### rtl/lcgis_gate_or.sv
// One gate of the cell: ORs every enabled true or inverted channel form.
// Assumes channel levels are already in the ref_clk_in domain.
`timescale 1ns/1ns
module lcgis_gate_or #(
  parameter int NUM_CH = lcgis_pkg::LCGIS_NUM_CHANNELS
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [2*NUM_CH-1:0] enable_in,
  input wire logic [NUM_CH-1:0] chan_in,
  output logic gate_out
);
  import lcgis_pkg::*;

  // A gate with no channel at all has nothing to combine
  generate
    if (NUM_CH < 1)
    begin : g_bad_param
      $error("lcgis_gate_or: NUM_CH must be at least one");
    end
  endgenerate

  // Both forms of every channel, laid out like the enable register
  logic [2*NUM_CH-1:0] forms;
  // Combined gate level before the output flop
  logic gate_next;

  // Pair each channel with its inverse in the enable bit order
  generate
    for (genvar k = 0; k < NUM_CH; k++)
    begin : g_form
      assign forms[2*k+LCGIS_EN_TRUE_OFS] = chan_in[k];
      assign forms[2*k+LCGIS_EN_INV_OFS] = ~chan_in[k];
    end
  endgenerate

  // Nothing enabled gives a constant low into the output flop
  assign gate_next = |(forms & enable_in);

  // Registered so the later stages see a glitch-free level
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      gate_out <= 1'b0;
    end
    else if (ce_in)
    begin
      gate_out <= gate_next;
    end
  end

endmodule

// ### rtl/lcgis_gate_input_select.sv
// Gate input selection for a configurable logic cell, with its registers.
// Assumes an Avalon-MM master on ref_clk_in, source pins from outside the
// clock domain, and channels 1 and 2 from logic on the same clock.
//
// Behaviour
// - Five-bit source select for channel three
// - Five-bit source select for channel four
// - Select bits seven to five read zero
// - Gate 0 bit 7 adds true channel four
// - Gate 0 bit 6 adds inverted channel four
// - Gate 0 bit 5 adds true channel three
// - Gate 0 bit 4 adds inverted channel three
// - Gate 0 bits 3,2 add channel two forms
// - Gate 0 bits 1,0 add channel one forms
// - Gate 1 register mirrors gate 0 layout
// - Implemented bits read and write; reset value open
//
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module lcgis_gate_input_select #(
  parameter int NUM_SOURCES = lcgis_pkg::LCGIS_NUM_SOURCES,
  parameter int SEL_WIDTH = lcgis_pkg::LCGIS_SEL_WIDTH
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [lcgis_pkg::LCGIS_ADDR_WIDTH-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [lcgis_pkg::LCGIS_DATA_WIDTH-1:0] avs_writedata_in,
  input wire logic [lcgis_pkg::LCGIS_BE_WIDTH-1:0] avs_byteenable_in,
  output logic [lcgis_pkg::LCGIS_DATA_WIDTH-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic [NUM_SOURCES-1:0] source_in,
  input wire logic cell_channel_1_signal_in,
  input wire logic cell_channel_2_signal_in,
  output logic cell_channel_3_signal_out,
  output logic cell_channel_4_signal_out,
  output logic gate0_out,
  output logic gate1_out
);
  import lcgis_pkg::*;

  // A select code must be able to reach every source, and no more than it can name
  generate
    if (NUM_SOURCES < 1 || NUM_SOURCES > (1 << SEL_WIDTH) || SEL_WIDTH > 8)
    begin : g_bad_param
      $error("lcgis: NUM_SOURCES does not fit the select width");
    end
  endgenerate

  // Source select registers, only the implemented low bits are stored
  logic [SEL_WIDTH-1:0] chan3_source_sel_reg;
  logic [SEL_WIDTH-1:0] chan4_source_sel_reg;
  // Gate enable registers, index 0 is gate 0
  logic [LCGIS_EN_WIDTH-1:0] gate_en_reg [LCGIS_NUM_GATES];
  // Two-stage synchroniser on the source pins
  logic [NUM_SOURCES-1:0] src_meta_reg;
  logic [NUM_SOURCES-1:0] src_sync_reg;
  // Selected channel levels
  logic chan3_reg;
  logic chan4_reg;
  // All four channels as one vector, first channel in bit 0
  logic [LCGIS_NUM_CHANNELS-1:0] chans;
  // Gate outputs from the gate flops
  logic [LCGIS_NUM_GATES-1:0] gates;
  // Bus handshake state
  logic ack_reg;
  logic req;
  logic take;
  logic [LCGIS_DATA_WIDTH-1:0] rdata_reg;
  logic [LCGIS_DATA_WIDTH-1:0] rdata_next;
  lcgis_reg_type sel_reg_hit;

  // Address decode, shared by the write and the read path
  function automatic lcgis_reg_type decode(input logic [LCGIS_ADDR_WIDTH-1:0] addr);
    lcgis_reg_type r;
    r = LCGIS_REG_NONE;
    unique case (addr)
      LCGIS_OFS_DATA3_SEL: r = LCGIS_REG_DATA3_SEL;
      LCGIS_OFS_DATA4_SEL: r = LCGIS_REG_DATA4_SEL;
      LCGIS_OFS_GATE0_EN: r = LCGIS_REG_GATE0_EN;
      LCGIS_OFS_GATE1_EN: r = LCGIS_REG_GATE1_EN;
      LCGIS_OFS_STATUS: r = LCGIS_REG_STATUS;
      // Any other word is unmapped
      default: r = LCGIS_REG_NONE;
    endcase
    return r;
  endfunction

  assign sel_reg_hit = decode(avs_address_in);

  // A request waits one cycle; the answer edge is the one after it.
  // Freezing the clock enable also holds off the answer.
  assign req = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~(ack_reg & ce_in);
  assign take = req & ack_reg & ce_in;

  // Handshake phase: set on the first cycle of a request, cleared at the answer
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      ack_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // Read mux, only the low lane carries data and everything above reads zero
  always_comb
  begin
    rdata_next = LCGIS_RDATA_ZERO;
    unique case (sel_reg_hit)
      LCGIS_REG_DATA3_SEL:
      begin
        rdata_next[LCGIS_SEL_LSB +: SEL_WIDTH] = chan3_source_sel_reg;
      end
      LCGIS_REG_DATA4_SEL:
      begin
        rdata_next[LCGIS_SEL_LSB +: SEL_WIDTH] = chan4_source_sel_reg;
      end
      LCGIS_REG_GATE0_EN:
      begin
        rdata_next[LCGIS_EN_WIDTH-1:0] = gate_en_reg[0];
      end
      LCGIS_REG_GATE1_EN:
      begin
        rdata_next[LCGIS_EN_WIDTH-1:0] = gate_en_reg[1];
      end
      LCGIS_REG_STATUS:
      begin
        // Live view of what the gates are looking at
        rdata_next[LCGIS_STAT_CHAN_LSB +: LCGIS_NUM_CHANNELS] = chans;
        rdata_next[LCGIS_STAT_GATE_LSB +: LCGIS_NUM_GATES] = gates;
      end
      LCGIS_REG_NONE:
      begin
        // Unmapped words read as zero
        rdata_next = LCGIS_RDATA_ZERO;
      end
    endcase
  end

  // Read data are captured in the waiting cycle and stand at the answer edge
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      rdata_reg <= LCGIS_RDATA_ZERO;
    end
    else if (ce_in && avs_read_in && !ack_reg)
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata_out = rdata_reg;

  // Source select writes; upper bits of the lane are dropped on purpose
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      // Software must not rely on this value, it only gives simulation a start
      chan3_source_sel_reg <= LCGIS_SEL_RESET[SEL_WIDTH-1:0];
      chan4_source_sel_reg <= LCGIS_SEL_RESET[SEL_WIDTH-1:0];
    end
    else if (take && avs_write_in && avs_byteenable_in[0])
    begin
      if (sel_reg_hit == LCGIS_REG_DATA3_SEL)
      begin
        chan3_source_sel_reg <= avs_writedata_in[LCGIS_SEL_LSB +: SEL_WIDTH];
      end
      if (sel_reg_hit == LCGIS_REG_DATA4_SEL)
      begin
        chan4_source_sel_reg <= avs_writedata_in[LCGIS_SEL_LSB +: SEL_WIDTH];
      end
    end
  end

  // Gate enable writes, both gates share one layout
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      gate_en_reg[0] <= LCGIS_EN_RESET;
      gate_en_reg[1] <= LCGIS_EN_RESET;
    end
    else if (take && avs_write_in && avs_byteenable_in[0])
    begin
      if (sel_reg_hit == LCGIS_REG_GATE0_EN)
      begin
        gate_en_reg[0] <= avs_writedata_in[LCGIS_EN_WIDTH-1:0];
      end
      if (sel_reg_hit == LCGIS_REG_GATE1_EN)
      begin
        gate_en_reg[1] <= avs_writedata_in[LCGIS_EN_WIDTH-1:0];
      end
    end
  end

  // Pins come from another domain, so two flops before anything reads them
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      src_meta_reg <= '0;
      src_sync_reg <= '0;
    end
    else if (ce_in)
    begin
      src_meta_reg <= source_in;
      src_sync_reg <= src_meta_reg;
    end
  end

  // Channel three and four source muxes; codes past NUM_SOURCES give low
  always_ff @(posedge ref_clk_in)
  begin
    if (rst_in)
    begin
      chan3_reg <= 1'b0;
      chan4_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      chan3_reg <= (32'(chan3_source_sel_reg) < NUM_SOURCES) ?
        src_sync_reg[chan3_source_sel_reg] : 1'b0;
      chan4_reg <= (32'(chan4_source_sel_reg) < NUM_SOURCES) ?
        src_sync_reg[chan4_source_sel_reg] : 1'b0;
    end
  end

  assign chans = {chan4_reg, chan3_reg, cell_channel_2_signal_in, cell_channel_1_signal_in};
  assign cell_channel_3_signal_out = chan3_reg;
  assign cell_channel_4_signal_out = chan4_reg;

  // One OR gate per enable register; the flop sits inside the gate
  generate
    for (genvar g = 0; g < LCGIS_NUM_GATES; g++)
    begin : g_gate
      lcgis_gate_or #(
        .NUM_CH(LCGIS_NUM_CHANNELS)
      ) u_gate (
        .ref_clk_in(ref_clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .enable_in(gate_en_reg[g]),
        .chan_in(chans),
        .gate_out(gates[g])
      );
    end
  endgenerate

  assign gate0_out = gates[0];
  assign gate1_out = gates[1];

  // Checks on the logic above, all on the one clock
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  // A taken write lands in the channel three select on the next cycle
  sel3_write_a: assert property (
    take && avs_write_in && avs_byteenable_in[0] && sel_reg_hit == LCGIS_REG_DATA3_SEL
    |=> chan3_source_sel_reg == $past(avs_writedata_in[LCGIS_SEL_LSB +: SEL_WIDTH]))
    else $error("channel three select not written");

  // Same for channel four, and the other select stays put
  sel4_write_a: assert property (
    take && avs_write_in && avs_byteenable_in[0] && sel_reg_hit == LCGIS_REG_DATA4_SEL
    |=> chan4_source_sel_reg == $past(avs_writedata_in[LCGIS_SEL_LSB +: SEL_WIDTH])
    && $stable(chan3_source_sel_reg))
    else $error("channel four select not written");

  // Unimplemented select bits always answer zero
  sel_upper_zero_a: assert property (
    take && avs_read_in
    && (sel_reg_hit == LCGIS_REG_DATA3_SEL || sel_reg_hit == LCGIS_REG_DATA4_SEL)
    |-> avs_readdata_out[LCGIS_DATA_WIDTH-1:SEL_WIDTH] == '0)
    else $error("select upper bits not zero");

  // True channel four alone drives gate 0
  g0_chan4_true_a: assert property (
    ce_in && gate_en_reg[0] == 8'h80 |=> gates[0] == $past(chan4_reg))
    else $error("gate 0 true channel four wrong");

  // Inverted channel four alone drives gate 0 inverted
  g0_chan4_inv_a: assert property (
    ce_in && gate_en_reg[0] == 8'h40 |=> gates[0] == !$past(chan4_reg))
    else $error("gate 0 inverted channel four wrong");

  // True channel three alone drives gate 0
  g0_chan3_true_a: assert property (
    ce_in && gate_en_reg[0] == 8'h20 |=> gates[0] == $past(chan3_reg))
    else $error("gate 0 true channel three wrong");

  // Inverted channel three alone drives gate 0 inverted
  g0_chan3_inv_a: assert property (
    ce_in && gate_en_reg[0] == 8'h10 |=> gates[0] == !$past(chan3_reg))
    else $error("gate 0 inverted channel three wrong");

  // Channel two forms in gate 0
  g0_chan2_a: assert property (
    ce_in && gate_en_reg[0] == 8'h08 ##1 ce_in && gate_en_reg[0] == 8'h04
    |=> gates[0] == !$past(cell_channel_2_signal_in)
    && $past(gates[0]) == $past(cell_channel_2_signal_in, 2))
    else $error("gate 0 channel two wrong");

  // Channel one forms in gate 0, both set makes it always high
  g0_chan1_a: assert property (
    ce_in && gate_en_reg[0] == 8'h03 |=> gates[0])
    else $error("gate 0 channel one pair wrong");

  // Gate 1 uses the same layout
  g1_layout_a: assert property (
    ce_in && gate_en_reg[1] == 8'h02 |=> gates[1] == $past(cell_channel_1_signal_in))
    else $error("gate 1 layout wrong");

  // A gate 0 enable read answers with the stored enables
  en_readback_a: assert property (
    take && avs_read_in && sel_reg_hit == LCGIS_REG_GATE0_EN
    |-> avs_readdata_out[LCGIS_EN_WIDTH-1:0] == gate_en_reg[0])
    else $error("gate 0 enables do not read back");

  // A taken gate 0 enable write lands on the next cycle
  en0_write_a: assert property (
    take && avs_write_in && avs_byteenable_in[0] && sel_reg_hit == LCGIS_REG_GATE0_EN
    |=> gate_en_reg[0] == $past(avs_writedata_in[LCGIS_EN_WIDTH-1:0]))
    else $error("gate 0 enables not written");

  // No enabled form gives a low gate
  gate_zero_a: assert property (
    ce_in && gate_en_reg[1] == 8'h00 |=> !gates[1])
    else $error("empty gate not low");

  // Every request is answered within two enabled cycles
  bus_answer_a: assert property (
    req && ce_in && !ack_reg ##1 ce_in |-> !avs_waitrequest_out)
    else $error("bus answer late");

endmodule

// ### test/lcgis_testbench.sv
// Self-checking bench for the gate input selection block and its registers.
// Assumes the design's one-cycle Avalon answer and registered gate outputs.
`timescale 1ns/1ns
module testbench;
  import lcgis_pkg::*;
  logic ref_clk_in;
  logic rst_in;
  logic ce_in;
  logic [4:0] avs_address_in;
  logic avs_read_in;
  logic avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0] avs_byteenable_in;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [31:0] source_in;
  logic cell_channel_1_signal_in;
  logic cell_channel_2_signal_in;
  logic cell_channel_3_signal_out;
  logic cell_channel_4_signal_out;
  logic gate0_out;
  logic gate1_out;
  // Expected read data, oldest first
  logic [31:0] exp_q[$];
  int fail_count;
  int num_checks;
  // Random state
  logic [31:0] seed;

  lcgis_gate_input_select dut (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .source_in(source_in),
    .cell_channel_1_signal_in(cell_channel_1_signal_in),
    .cell_channel_2_signal_in(cell_channel_2_signal_in),
    .cell_channel_3_signal_out(cell_channel_3_signal_out),
    .cell_channel_4_signal_out(cell_channel_4_signal_out),
    .gate0_out(gate0_out),
    .gate1_out(gate1_out)
  );

  // Free-running 50 MHz clock
  initial
  begin
    ref_clk_in = 1'b0;
    forever #10 ref_clk_in = ~ref_clk_in;
  end

  // Xorshift source, fixed start
  function automatic logic [31:0] xrand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Reference gate: OR of every enabled true or inverted channel form
  function automatic logic gexp(input logic [7:0] en, input logic [3:0] ch);
    logic g;
    g = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      g |= (en[2*k+1] & ch[k]) | (en[2*k] & ~ch[k]);
    end
    return g;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Holds the request until waitrequest is seen low at a rising edge;
  // a slave that never answers is caught by the watchdog
  task automatic bus_wait();
    do
      @(posedge ref_clk_in);
    while (avs_waitrequest_out !== 1'b0);
  endtask

  task automatic bus_write(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_write_in <= 1'b1;
    bus_wait();
    avs_write_in <= 1'b0;
  endtask

  task automatic bus_read(input logic [4:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    @(posedge ref_clk_in);
    avs_address_in <= a;
    avs_read_in <= 1'b1;
    bus_wait();
    avs_read_in <= 1'b0;
  endtask

  // Monitor: takes the oldest note whenever a read is answered
  always @(posedge ref_clk_in)
  begin
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0)
    begin
      if (exp_q.size() == 0)
        check(avs_readdata_out, 32'hFFFF_FFFF, "read with no note");
      else
        check(avs_readdata_out, exp_q.pop_front(), "read data");
    end
  end

  // Programs both selects and gates, drives channels, then checks gates and status
  task automatic apply(input logic [7:0] e0, input logic [7:0] e1);
    logic [4:0] s3;
    logic [4:0] s4;
    logic [31:0] src;
    logic [3:0] ch;
    logic [1:0] g;
    s3 = 5'(xrand());
    s4 = 5'(xrand());
    src = xrand();
    ch[1:0] = 2'(xrand());
    ch[2] = src[s3];
    ch[3] = src[s4];
    bus_write(LCGIS_OFS_DATA3_SEL, {27'h0, s3}, 4'h1);
    bus_write(LCGIS_OFS_DATA4_SEL, {27'h0, s4}, 4'h1);
    bus_write(LCGIS_OFS_GATE0_EN, {24'h0, e0}, 4'h1);
    bus_write(LCGIS_OFS_GATE1_EN, {24'h0, e1}, 4'h1);
    @(posedge ref_clk_in);
    source_in <= src;
    cell_channel_1_signal_in <= ch[0];
    cell_channel_2_signal_in <= ch[1];
    // Source pins need two sync flops plus the channel and gate flops
    repeat (6) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    g = {gexp(e1, ch), gexp(e0, ch)};
    check({31'h0, gate0_out}, {31'h0, g[0]}, "gate 0");
    check({31'h0, gate1_out}, {31'h0, g[1]}, "gate 1");
    check({31'h0, cell_channel_3_signal_out}, {31'h0, ch[2]}, "channel 3");
    check({31'h0, cell_channel_4_signal_out}, {31'h0, ch[3]}, "channel 4");
    bus_read(LCGIS_OFS_STATUS, {26'h0, g, ch});
    bus_read(LCGIS_OFS_GATE0_EN, {24'h0, e0});
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under this many cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk_in);
    fail_count++;
    $display("Error at %0t: run did not finish", $time);
    final_report();
  end

  // Main sequence
  initial
  begin
    seed = 32'h0000_5935;
    fail_count = 0;
    num_checks = 0;
    rst_in = 1'b1;
    ce_in = 1'b1;
    avs_address_in = 5'h00;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0000_0000;
    avs_byteenable_in = 4'h0;
    source_in = 32'h0000_0000;
    cell_channel_1_signal_in = 1'b0;
    cell_channel_2_signal_in = 1'b0;
    repeat (10) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    // Upper select bits are dropped and read back zero
    bus_write(LCGIS_OFS_DATA3_SEL, 32'hFFFF_FFFF, 4'hF);
    bus_read(LCGIS_OFS_DATA3_SEL, 32'h0000_001F);
    bus_write(LCGIS_OFS_DATA4_SEL, 32'h0000_00EA, 4'h1);
    bus_read(LCGIS_OFS_DATA4_SEL, 32'h0000_000A);
    bus_write(LCGIS_OFS_GATE0_EN, 32'h0000_01A5, 4'h1);
    bus_write(LCGIS_OFS_GATE1_EN, 32'h0000_005A, 4'h1);
    bus_read(LCGIS_OFS_GATE1_EN, 32'h0000_005A);
    // Low byte lane off: the write must leave the register alone
    bus_write(LCGIS_OFS_GATE1_EN, 32'h0000_00FF, 4'hE);
    bus_read(LCGIS_OFS_GATE1_EN, 32'h0000_005A);
    // Unmapped word: write ignored, reads zero
    bus_write(5'h14, 32'h0000_00FF, 4'hF);
    bus_read(5'h14, 32'h0000_0000);
    // Clock enable low stretches the answer; the read must still land
    fork
      bus_read(LCGIS_OFS_GATE0_EN, 32'h0000_00A5);
      begin
        @(posedge ref_clk_in);
        ce_in <= 1'b0;
        repeat (3) @(posedge ref_clk_in);
        ce_in <= 1'b1;
      end
    join
    // No form enabled gives a quiet gate
    apply(8'h00, 8'h00);
    // Each enable bit alone on gate 0, all others on gate 1; top bit first so
    // the true then inverted channel two forms follow each other directly
    for (int b = 7; b >= 0; b--)
    begin
      apply(8'h01 << b, ~(8'h01 << b));
    end
    // Both channel one forms on gate 0, true channel one alone on gate 1
    apply(8'h03, 8'h02);
    // Random enables, selects and channel levels
    for (int i = 0; i < 16; i++)
    begin
      apply(8'(xrand()), 8'(xrand()));
    end
    final_report();
  end
endmodule
